// ---- cct_far_end.sv ----
// Far-side model: external count clock source and channel pin drivers.
`timescale 1ns/1ns
module cct_far_end (
  // Clock.
  input  wire logic       clk_i,
  // Bench commands.
  input  wire logic       ext_run_i,
  input  wire logic [3:0] drive_i,
  // Timer pins.
  input  wire logic [3:0] pin_o_i,
  input  wire logic [3:0] pin_oe_i,
  output logic            ext_clk_o,
  output logic [3:0]      wire_o
);
  int ph = 0;

  initial ext_clk_o = 1'b0;

  // Seven cycles high and seven low keep the pin near 3.6 MHz.
  always @(posedge clk_i) begin
    if (ext_run_i) begin
      ph <= (ph == 6) ? 0 : ph + 1;
      if (ph == 6) ext_clk_o <= ~ext_clk_o;
    end
  end

  // A pin the timer drives shows its level; otherwise the far side drives it.
  assign wire_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & drive_i);
endmodule

// ---- cct_pkg.sv ----
// Constants, register map and state types of the capture/compare timer.
// Function
// [R1] Overflow toggle bit inverts a compare pin at each overflow; reset clears.
// [R2] Overflow toggle wins over a compare match in the same count.
// [R3] With overflow toggle clear, full-duty bit forces 100% PWM duty.
// [R4] Full-duty changes act from the next PWM period onward.
// [R5] Each channel holds a 16-bit value as high and low bytes.
// [R6] In capture mode a high-byte read blocks captures until low read.
// [R7] In compare mode a high-byte write blocks compares until low written.
// [R8] One 16-bit up-counter, free running or modulo, times all channels.
// [R9] The modulo byte pair is the terminal count of the counter.
// [R10] Reading the counter never disturbs its counting.
// [R11] Each of four channels is capture or compare independently.
// [R12] A 3-bit select picks one of seven bus dividers or the pin.
// [R13] The external clock pin must stay at or below 4 MHz.
// [R14] An active capture edge copies the counter into the channel value.
// [R15] Capture edge is rising, falling or either, per channel.
// [R16] Captures can raise a channel interrupt request.
// [R17] A compare match sets, clears or toggles the channel pin.
// [R18] Compare matches can raise a channel interrupt request.
// [R19] Unbuffered compare writes replace the active value at once.
// [R20] Software should lower a compare value from the compare handler.
// [R21] Software should raise a compare value from the overflow handler.
// [R22] Control bits halt the counter and clear counter with prescaler.
// [R23] At the modulo value set overflow flag and restart from zero.
// [R24] Select codes 0..6 divide by 1..64; code 7 picks the pin.
// [R25] Edge codes: capture rise/fall/both; compare toggle/clear/set; 00 off.
// [R26] Event flag clears by read-with-flag-set then zero write; events win.
// [R27] Clock pin and capture pins are synchronised before edge detection.
package cct_pkg;

  localparam int CCT_NCH = 4;

  localparam logic [7:0] CCT_ADR_SC        = 8'h00;
  localparam logic [7:0] CCT_ADR_CNT_HI    = 8'h04;
  localparam logic [7:0] CCT_ADR_CNT_LO    = 8'h08;
  localparam logic [7:0] CCT_ADR_MOD_HI    = 8'h0C;
  localparam logic [7:0] CCT_ADR_MOD_LO    = 8'h10;
  localparam logic [7:0] CCT_ADR_CH_BASE   = 8'h14;
  localparam logic [7:0] CCT_ADR_CH_STRIDE = 8'h0C;
  localparam logic [7:0] CCT_OFS_CH_CTRL   = 8'h00;
  localparam logic [7:0] CCT_OFS_CH_HI     = 8'h04;
  localparam logic [7:0] CCT_OFS_CH_LO     = 8'h08;

  // Timer status and control bit positions.
  localparam int CCT_SC_TOF   = 7;
  localparam int CCT_SC_TOIE  = 6;
  localparam int CCT_SC_HALT  = 5;
  localparam int CCT_SC_CLEAR = 4;

  // Channel control bit positions.
  localparam int CCT_CH_FLAG = 7;
  localparam int CCT_CH_IE   = 6;
  localparam int CCT_CH_MSB  = 5;
  localparam int CCT_CH_MSA  = 4;
  localparam int CCT_CH_ELSB = 3;
  localparam int CCT_CH_ELSA = 2;
  localparam int CCT_CH_TOV  = 1;
  localparam int CCT_CH_MAX  = 0;

  localparam logic [15:0] CCT_MOD_RESET = 16'hFFFF;
  localparam logic [2:0]  CCT_SEL_EXT   = 3'h7;
  localparam logic [2:0]  CCT_SEL_TOP   = 3'h6;
  localparam logic [5:0]  CCT_DIV_ONES  = 6'h3F;

  localparam logic [1:0] CCT_ELS_OFF  = 2'h0;
  localparam logic [1:0] CCT_ELS_TGL  = 2'h1;
  localparam logic [1:0] CCT_ELS_CLR  = 2'h2;
  localparam logic [1:0] CCT_ELS_SET  = 2'h3;

  typedef struct packed {
    logic        flag;
    logic        ie;
    logic        msb;
    logic        msa;
    logic        elsb;
    logic        elsa;
    logic        tov;
    logic        maxd;
    logic        max_eff;
    logic [15:0] val;
    logic        cap_blk;
    logic        cmp_blk;
    logic        arm;
    logic        s1;
    logic        s2;
    logic        prev;
    logic        pin;
    logic        oe;
  } cct_chan_s;

  typedef struct packed {
    logic [15:0]                cnt;
    logic [15:0]                modv;
    logic                       tof;
    logic                       toie;
    logic                       halt;
    logic [2:0]                 psel;
    logic                       tof_arm;
    logic                       ovf_blk;
    logic [7:0]                 cnt_lat;
    logic                       cnt_latched;
    cct_chan_s [CCT_NCH-1:0]    ch;
    logic                       ack;
    logic [7:0]                 rdat;
    logic [CCT_NCH-1:0]         irq;
    logic                       ovf_irq;
  } cct_state_s;

  typedef struct packed {
    logic [5:0] div;
    logic       e1;
    logic       e2;
    logic       eprev;
  } cct_pre_s;

endpackage

// ---- cct_prescaler.sv ----
// Bus clock prescaler and external clock edge detector.
`timescale 1ns/1ns
module cct_prescaler (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Link to the timer core.
  cct_tick_if.pre   lnk
);
  import cct_pkg::*;

  cct_pre_s   s;
  cct_pre_s   next_s;
  logic [5:0] mask;

  always_comb begin
    next_s = s;
    next_s.e1 = lnk.ext_pin;  // [R27]
    next_s.e2 = s.e1;
    next_s.eprev = s.e2;
    next_s.div = lnk.clear ? 6'h00 : s.div + 6'h01;  // [R22]
    mask = CCT_DIV_ONES >> (CCT_SEL_TOP - lnk.sel);
    if (lnk.clear) begin
      lnk.tick = 1'b0;
    end else if (lnk.sel == CCT_SEL_EXT) begin
      lnk.tick = s.e2 & ~s.eprev;  // [R12] [R24] [R27]
    end else begin
      lnk.tick = (s.div & mask) == mask;  // [R24]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// ---- cct_tick_if.sv ----
// Link between the timer core and its clock prescaler.
`timescale 1ns/1ns
interface cct_tick_if;
  logic [2:0] sel;
  logic       clear;
  logic       ext_pin;
  logic       tick;

  modport core (output sel, output clear, output ext_pin, input tick);
  modport pre  (input sel, input clear, input ext_pin, output tick);
endinterface

// ---- cct_timer.sv ----
// Four-channel 16-bit capture/compare timer with a Wishbone slave.
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
module cct_timer (
  // Clock and reset.
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // Wishbone slave.
  input  wire logic [7:0]                  wb_adr_i,
  input  wire logic [31:0]                 wb_dat_i,
  input  wire logic                        wb_we_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  // Timer pins.
  input  wire logic                        external_count_clock_pin_i,
  input  wire logic [cct_pkg::CCT_NCH-1:0] channel_pin_i,
  output logic      [cct_pkg::CCT_NCH-1:0] channel_pin_o,
  output logic      [cct_pkg::CCT_NCH-1:0] channel_pin_oe_o,
  // Interrupt requests.
  output logic      [cct_pkg::CCT_NCH-1:0] chan_irq_o,
  output logic                             ovf_irq_o
);
  import cct_pkg::*;

  cct_state_s s;
  cct_state_s next_s;
  cct_tick_if lnk ();

  cct_prescaler u_pre (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .lnk   (lnk.pre)
  );

  logic       acc;
  logic       wr;
  logic       rd;
  logic [7:0] d;
  logic [7:0] rdat;
  logic       tick;
  logic       ovf;
  logic       clr;
  logic [7:0] cb;
  logic       cap_mode;
  logic       active;
  logic [1:0] els;
  logic       rise;
  logic       fall;
  logic       cap_evt;
  logic       cmp_evt;
  logic       ovf_tgl;
  cct_chan_s  c;
  cct_chan_s  nc;

  assign lnk.sel = s.psel;
  assign lnk.ext_pin = external_count_clock_pin_i;

  always_comb begin
    next_s = s;
    c = s.ch[0];
    nc = c;
    cb = CCT_ADR_CH_BASE;
    cap_mode = 1'b0;
    active = 1'b0;
    els = CCT_ELS_OFF;
    rise = 1'b0;
    fall = 1'b0;
    cap_evt = 1'b0;
    cmp_evt = 1'b0;
    ovf_tgl = 1'b0;
    acc = wb_cyc_i & wb_stb_i & ~s.ack;
    wr = acc & wb_we_i & wb_sel_i[0];
    rd = acc & ~wb_we_i;
    d = wb_dat_i[7:0];
    rdat = 8'h00;
    next_s.ack = acc;
    clr = wr & (wb_adr_i == CCT_ADR_SC) & d[CCT_SC_CLEAR];
    lnk.clear = clr;

    // Counter time base.
    tick = lnk.tick & ~s.halt;  // [R22]
    ovf = tick & (s.cnt == s.modv);  // [R9] [R23]
    if (tick) begin
      next_s.cnt = ovf ? 16'h0000 : s.cnt + 16'h0001;  // [R8] [R23]
    end

    // Timer status and control register.
    if (wb_adr_i == CCT_ADR_SC) begin
      rdat = {s.tof, s.toie, s.halt, 1'b0, 1'b0, s.psel};
      if (rd && s.tof) begin
        next_s.tof_arm = 1'b1;
      end
      if (wr) begin
        next_s.toie = d[CCT_SC_TOIE];
        next_s.halt = d[CCT_SC_HALT];
        next_s.psel = d[2:0];  // [R12]
        if (!d[CCT_SC_TOF] && (s.tof_arm || !s.toie)) begin
          next_s.tof = 1'b0;
          next_s.tof_arm = 1'b0;
        end
      end
    end
    if (clr) begin
      next_s.cnt = 16'h0000;  // [R22]
    end
    if (ovf && !s.ovf_blk) begin
      next_s.tof = 1'b1;  // [R23]
      next_s.tof_arm = 1'b0;
    end

    // Counter bytes: a high read freezes the low byte until it is read.
    if (rd && wb_adr_i == CCT_ADR_CNT_HI) begin
      rdat = s.cnt[15:8];  // [R10]
      if (!s.cnt_latched) begin
        next_s.cnt_lat = s.cnt[7:0];
        next_s.cnt_latched = 1'b1;
      end
    end
    if (rd && wb_adr_i == CCT_ADR_CNT_LO) begin
      rdat = s.cnt_latched ? s.cnt_lat : s.cnt[7:0];  // [R10]
      next_s.cnt_latched = 1'b0;
    end

    // Modulo bytes: a high write holds off the overflow flag.
    if (wb_adr_i == CCT_ADR_MOD_HI) begin
      rdat = s.modv[15:8];
      if (wr) begin
        next_s.modv[15:8] = d;  // [R9]
        next_s.ovf_blk = 1'b1;
      end
    end
    if (wb_adr_i == CCT_ADR_MOD_LO) begin
      rdat = s.modv[7:0];
      if (wr) begin
        next_s.modv[7:0] = d;  // [R9]
        next_s.ovf_blk = 1'b0;
      end
    end

    // Channels, each set up independently.
    for (int i = 0; i < CCT_NCH; i++) begin  // [R11]
      c = s.ch[i];
      nc = c;
      cb = CCT_ADR_CH_BASE + 8'(i) * CCT_ADR_CH_STRIDE;
      cap_mode = ~c.msb & ~c.msa;
      els = {c.elsb, c.elsa};
      active = els != CCT_ELS_OFF;
      nc.s1 = channel_pin_i[i];  // [R27]
      nc.s2 = c.s1;
      nc.prev = c.s2;
      rise = c.s2 & ~c.prev;
      fall = ~c.s2 & c.prev;
      cap_evt = cap_mode & ~c.cap_blk
              & ((c.elsa & rise) | (c.elsb & fall));  // [R15] [R25] [R6]
      cmp_evt = ~cap_mode & active & tick & ~c.cmp_blk
              & (s.cnt == c.val);  // [R17] [R7]
      ovf_tgl = ~cap_mode & active & c.tov & ovf;  // [R1]

      if (wb_adr_i == cb + CCT_OFS_CH_CTRL) begin
        rdat = {c.flag, c.ie, c.msb, c.msa, c.elsb, c.elsa, c.tov, c.maxd};
        if (rd && c.flag) begin
          nc.arm = 1'b1;
        end
        if (wr) begin
          nc.ie = d[CCT_CH_IE];
          nc.msb = d[CCT_CH_MSB];
          nc.msa = d[CCT_CH_MSA];
          nc.elsb = d[CCT_CH_ELSB];
          nc.elsa = d[CCT_CH_ELSA];
          nc.tov = d[CCT_CH_TOV];
          nc.maxd = d[CCT_CH_MAX];
          if (!d[CCT_CH_FLAG] && (c.arm || !c.ie)) begin
            nc.flag = 1'b0;  // [R26]
            nc.arm = 1'b0;
          end
        end
      end
      if (wb_adr_i == cb + CCT_OFS_CH_HI) begin
        rdat = c.val[15:8];  // [R5]
        if (rd && cap_mode) begin
          nc.cap_blk = 1'b1;  // [R6]
        end
        if (wr) begin
          nc.val[15:8] = d;  // [R19]
          nc.cmp_blk = ~cap_mode;  // [R7]
        end
      end
      if (wb_adr_i == cb + CCT_OFS_CH_LO) begin
        rdat = c.val[7:0];  // [R5]
        if (rd) begin
          nc.cap_blk = 1'b0;  // [R6]
        end
        if (wr) begin
          nc.val[7:0] = d;  // [R19]
          nc.cmp_blk = 1'b0;  // [R7]
        end
      end

      if (cap_evt) begin
        nc.val = s.cnt;  // [R14]
      end
      if (cap_evt || cmp_evt) begin
        nc.flag = 1'b1;  // [R26]
        nc.arm = 1'b0;
      end

      // Pin level: preset when disconnected, else overflow beats compare.
      if (!active) begin
        nc.pin = ~c.msa;
      end else if (!cap_mode) begin
        if (ovf_tgl) begin
          nc.pin = ~c.pin;  // [R1] [R2]
        end else if (cmp_evt) begin
          unique case (els)
            CCT_ELS_TGL: nc.pin = ~c.pin;  // [R25]
            CCT_ELS_CLR: nc.pin = 1'b0;  // [R25]
            CCT_ELS_SET: nc.pin = 1'b1;  // [R25]
            default:     nc.pin = c.pin;
          endcase
        end
      end
      if (ovf) begin
        nc.max_eff = c.maxd;  // [R4]
      end
      if (c.max_eff && !c.tov && !cap_mode && active) begin
        nc.pin = 1'b1;  // [R3]
      end
      if (rst_i) begin
        nc.pin = ~c.msa;
      end
      nc.oe = (nc.elsb | nc.elsa) & (nc.msb | nc.msa);
      next_s.irq[i] = nc.flag & nc.ie;  // [R16] [R18]
      next_s.ch[i] = nc;
    end

    next_s.ovf_irq = next_s.tof & next_s.toie;
    if (rd) begin
      next_s.rdat = rdat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.modv <= CCT_MOD_RESET;
      for (int i = 0; i < CCT_NCH; i++) begin
        s.ch[i].pin <= 1'b1;
      end
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    wb_dat_o = {24'h000000, s.rdat};
    wb_ack_o = s.ack;
    for (int i = 0; i < CCT_NCH; i++) begin
      channel_pin_o[i] = s.ch[i].pin;
      channel_pin_oe_o[i] = s.ch[i].oe;
    end
    chan_irq_o = s.irq;
    ovf_irq_o = s.ovf_irq;
  end
endmodule

// ---- cct_timer_properties.sv ----
// Bus handshake and pin ownership properties of the capture/compare timer.
`timescale 1ns/1ns
module cct_timer_properties (
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Wishbone slave.
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Timer pins.
  input wire logic        external_count_clock_pin_i,
  input wire logic [3:0]  channel_pin_i,
  input wire logic [3:0]  channel_pin_o,
  input wire logic [3:0]  channel_pin_oe_o,
  // Interrupt requests.
  input wire logic [3:0]  chan_irq_o,
  input wire logic        ovf_irq_o
);
  logic wr_ok;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  assign wr_ok = wb_ack_o & wb_we_i & wb_sel_i[0];

  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  property p_ack_answer;
    s_take |=> s_pulse;
  endproperty
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o);
  endproperty
  property p_dat_high;
    wb_dat_o[31:8] == 24'h000000;
  endproperty
  property p_dat_read;
    $changed(wb_dat_o) |-> wb_ack_o && !wb_we_i;
  endproperty
  property p_oe_write;
    $changed(channel_pin_oe_o) |-> wr_ok || $past(wr_ok);
  endproperty
  property p_pin_idle;
    ((channel_pin_o ^ $past(channel_pin_o)) & ~channel_pin_oe_o
      & ~$past(channel_pin_oe_o)) != 4'h0 |-> wr_ok || $past(wr_ok);
  endproperty
  // A request falls at the edge that raises ack, so the write is seen now.
  property p_irq_fall;
    ($past(chan_irq_o) & ~chan_irq_o) != 4'h0 |-> wr_ok || $past(wr_ok);
  endproperty
  property p_ovf_fall;
    $fell(ovf_irq_o) |-> wr_ok || $past(wr_ok);
  endproperty

  a_ack_answer: assert property (p_ack_answer)
    else $error("ack not a single pulse after request");
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without a request");
  a_dat_high: assert property (p_dat_high)
    else $error("upper read data not zero");
  a_dat_read: assert property (p_dat_read)
    else $error("read data moved outside a read");
  a_oe_write: assert property (p_oe_write)
    else $error("pin enable moved without a write");
  a_pin_idle: assert property (p_pin_idle)
    else $error("undriven pin level moved without a write");
  a_irq_fall: assert property (p_irq_fall)
    else $error("channel request dropped without a write");
  a_ovf_fall: assert property (p_ovf_fall)
    else $error("overflow request dropped without a write");
endmodule

bind cct_timer cct_timer_properties chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .external_count_clock_pin_i(external_count_clock_pin_i),
  .channel_pin_i(channel_pin_i), .channel_pin_o(channel_pin_o),
  .channel_pin_oe_o(channel_pin_oe_o), .chan_irq_o(chan_irq_o),
  .ovf_irq_o(ovf_irq_o));

// ---- test_four_channel_capture_compare_timer.sv ----
// Self-checking bench for the capture/compare timer.
`timescale 1ns/1ns
module test_four_channel_capture_compare_timer;
  import cct_pkg::*;
  logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic        ovf_irq_o, ext_run, ext_clk;
  logic [7:0]  wb_adr_i, q;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0]  wb_sel_i, pin_o, pin_oe, chan_irq_o, drv, pins;
  int          failures = 0, comparisons = 0, m, v, t, c, ones;

  cct_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .external_count_clock_pin_i(ext_clk),
    .channel_pin_i(pins), .channel_pin_o(pin_o), .channel_pin_oe_o(pin_oe),
    .chan_irq_o(chan_irq_o), .ovf_irq_o(ovf_irq_o));
  cct_far_end far_u (.clk_i(clk_i), .ext_run_i(ext_run), .drive_i(drv),
    .pin_o_i(pin_o), .pin_oe_i(pin_oe), .ext_clk_o(ext_clk), .wire_o(pins));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  function automatic logic [7:0] ca(input int n, input int o);
    return 8'(CCT_ADR_CH_BASE + CCT_ADR_CH_STRIDE * n + o);
  endfunction

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_we_i  <= w;
    wb_dat_i <= {24'h000000, d};
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n == 20) failures++;
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Counts edges until the channel pin changes level.
  task automatic hold(input int ch, output int n);
    logic p;
    n = 0;
    p = pin_o[ch];
    while (pin_o[ch] === p && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic results;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk_i);
    failures++;
    results;
  end

  initial begin
    {rst_i, wb_we_i, wb_cyc_i, wb_stb_i, ext_run} = 5'h10;
    {wb_adr_i, wb_dat_i, drv, wb_sel_i} = {40'h0, 4'h0, 4'hF};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    v = $urandom(32'hA082);
    chk(16'(pin_oe), 16'h0000);
    bus(CCT_ADR_MOD_HI, 1'b0, 8'h00);
    chk(16'(q), 16'h00FF);
    bus(CCT_ADR_MOD_LO, 1'b0, 8'h00);
    chk(16'(q), 16'h00FF);
    bus(CCT_ADR_SC, 1'b0, 8'h00);
    chk(16'(q), 16'h0000);
    for (int n = 0; n < 4; n++) begin
      bus(ca(n, 0), 1'b0, 8'h00);
      chk(16'(q), 16'h0000);
    end
    bus(8'hFC, 1'b0, 8'h00);
    chk(16'(q), 16'h0000);
    bus(CCT_ADR_SC, 1'b1, 8'h30);
    bus(CCT_ADR_CNT_HI, 1'b0, 8'h00);
    chk(16'(q), 16'h0000);
    bus(CCT_ADR_CNT_LO, 1'b0, 8'h00);
    chk(16'(q), 16'h0000);
    m = 3 + $urandom % 6;
    v = $urandom % (m + 1);
    bus(CCT_ADR_MOD_HI, 1'b1, 8'h00);
    bus(CCT_ADR_MOD_LO, 1'b1, 8'(m));
    // Compare values are written while the counter is halted.
    for (int n = 0; n < 3; n++) begin
      bus(ca(n, 4), 1'b1, 8'h00);
      bus(ca(n, 8), 1'b1, 8'((n == 1) ? m : v));
    end
    bus(ca(0, 0), 1'b1, 8'h14);
    for (int ps = 0; ps < 8; ps++) begin
      ext_run <= (ps == 7);
      bus(CCT_ADR_SC, 1'b1, 8'(ps));
      hold(0, t);
      hold(0, t);
      chk(16'(t), 16'((m + 1) * ((ps == 7) ? 14 : (1 << ps))));
    end
    ext_run <= 1'b0;
    bus(CCT_ADR_SC, 1'b0, 8'h00);
    chk(16'(q[7]), 16'h0001);
    bus(CCT_ADR_SC, 1'b1, 8'h20);
    bus(CCT_ADR_SC, 1'b1, 8'h20);
    bus(CCT_ADR_SC, 1'b0, 8'h00);
    chk(16'(q), 16'h0020);
    bus(CCT_ADR_SC, 1'b1, 8'h00);
    for (int k = 0; k < 4; k++) begin
      if (k != 1) begin
        bus(ca(0, 0), 1'b1, 8'(8'h10 | (k << 2)));
        repeat (2 * m + 6) @(posedge clk_i);
        chk(16'({pin_oe[0], pin_o[0]}), 16'((k == 0) ? 0 : k));
      end
    end
    bus(ca(1, 0), 1'b1, 8'h1A);
    hold(1, t);
    hold(1, t);
    chk(16'(t), 16'(m + 1));
    bus(ca(2, 0), 1'b1, 8'h19);
    repeat (3 * (m + 1)) @(posedge clk_i);
    ones = 0;
    repeat (2 * (m + 1)) begin
      @(posedge clk_i);
      ones += pin_o[2];
    end
    chk(16'(ones), 16'(2 * (m + 1)));
    bus(ca(2, 0), 1'b1, 8'h18);
    @(negedge clk_i);
    chk(16'(pin_o[2]), 16'h0001);
    repeat (3 * (m + 1)) @(posedge clk_i);
    chk(16'(pin_o[2]), 16'h0000);
    bus(CCT_ADR_SC, 1'b1, 8'h20);
    bus(CCT_ADR_CNT_HI, 1'b0, 8'h00);
    c = q << 8;
    bus(CCT_ADR_CNT_LO, 1'b0, 8'h00);
    c = c | q;
    for (int k = 1; k < 4; k++) begin
      for (int e = 0; e < 2; e++) begin
        bus(ca(3, 0), 1'b1, 8'(k << 2));
        drv[3] <= ~drv[3];
        repeat (8) @(posedge clk_i);
        bus(ca(3, 0), 1'b0, 8'h00);
        chk(16'(q[7]), 16'((k >> e) & 1));
      end
    end
    bus(ca(3, 4), 1'b0, 8'h00);
    t = q;
    bus(ca(3, 8), 1'b0, 8'h00);
    chk({t[7:0], q}, 16'(c));
    bus(ca(3, 4), 1'b0, 8'h00);
    bus(CCT_ADR_SC, 1'b1, 8'h00);
    bus(CCT_ADR_SC, 1'b1, 8'h20);
    drv[3] <= 1'b1;
    repeat (8) @(posedge clk_i);
    bus(ca(3, 8), 1'b0, 8'h00);
    chk(16'(q), 16'(c & 255));
    bus(ca(3, 0), 1'b1, 8'h4C);
    drv[3] <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(16'(chan_irq_o[3]), 16'h0001);
    bus(ca(3, 0), 1'b1, 8'h4C);
    repeat (2) @(posedge clk_i);
    chk(16'(chan_irq_o[3]), 16'h0001);
    bus(ca(3, 0), 1'b0, 8'h00);
    bus(ca(3, 0), 1'b1, 8'h4C);
    repeat (2) @(posedge clk_i);
    chk(16'(chan_irq_o[3]), 16'h0000);
    bus(CCT_ADR_SC, 1'b1, 8'h40);
    repeat (m + 6) @(posedge clk_i);
    chk(16'(ovf_irq_o), 16'h0001);
    bus(CCT_ADR_SC, 1'b1, 8'h60);
    bus(CCT_ADR_SC, 1'b0, 8'h00);
    bus(CCT_ADR_SC, 1'b1, 8'h60);
    repeat (2) @(posedge clk_i);
    chk(16'(ovf_irq_o), 16'h0000);
    results;
  end
endmodule
